//--- design/wsr_pkg.sv
package wsr_pkg;

  // Register word indices, and the byte addresses derived from them
  localparam logic [7:0] WSR_RATE_CTRL_IDX = 8'h12;
  localparam logic [7:0] WSR_STATUS_IDX = 8'h13;
  localparam int WSR_ADDR_W = 8;
  localparam logic [WSR_ADDR_W-1:0] WSR_RATE_CTRL_ADDR = {WSR_RATE_CTRL_IDX[5:0], 2'b00};
  localparam logic [WSR_ADDR_W-1:0] WSR_STATUS_ADDR = {WSR_STATUS_IDX[5:0], 2'b00};

  // Rate-control field layout and reset value
  localparam int WSR_WATCH_LSB = 0;
  localparam int WSR_ZERO_BIT = 4;
  localparam int WSR_STANDBY_LSB = 5;
  localparam logic [7:0] WSR_RATE_CTRL_RST = 8'h00;

  // Power-mode selector values
  localparam logic [2:0] WSR_PM_ULP = 3'h3;
  localparam logic [2:0] WSR_PM_LP = 3'h0;
  localparam logic [2:0] WSR_PM_PREC = 3'h4;

  // AXI responses
  localparam logic [1:0] WSR_RESP_OKAY = 2'h0;
  localparam logic [1:0] WSR_RESP_SLVERR = 2'h2;

  // Clock timing
  localparam int WSR_CLK_PERIOD_NS = 4;
  localparam int WSR_CLK_HZ = 1000000000 / WSR_CLK_PERIOD_NS;
  localparam int WSR_RATE_W = 16;

  typedef struct packed {
    logic [2:0] standby_clock_code;
    logic zero_bit;
    logic [3:0] watch_rate_code;
  } wsr_rate_ctrl_t;

  typedef struct packed {
    logic power_mode_known;
    logic watch_code_supported;
  } wsr_status_t;

  // Activity-watch rate in tenths of a hertz, zero where unsupported
  function automatic logic [WSR_RATE_W-1:0] wsr_watch_dhz(input logic [2:0] pm, input logic [3:0] code);
    logic [WSR_RATE_W-1:0] r;
    r = 16'h0000;
    case (pm)
      WSR_PM_ULP: begin
        case (code)
          4'h0, 4'h4: r = 16'd60;
          4'h1: r = 16'd4;
          4'h2: r = 16'd8;
          4'h3: r = 16'd15;
          4'h5: r = 16'd130;
          4'h6: r = 16'd250;
          4'h7: r = 16'd500;
          4'h8: r = 16'd1000;
          4'h9: r = 16'd1900;
          4'ha: r = 16'd3800;
          4'hb: r = 16'd7500;
          4'hc: r = 16'd11000;
          4'hf: r = 16'd13000;
          default: r = 16'h0000;
        endcase
      end
      WSR_PM_LP: begin
        case (code)
          4'h0, 4'h4: r = 16'd70;
          4'h1: r = 16'd4;
          4'h2: r = 16'd8;
          4'h3: r = 16'd15;
          4'h5: r = 16'd140;
          4'h6: r = 16'd280;
          4'h7: r = 16'd540;
          4'h8: r = 16'd1050;
          4'h9: r = 16'd2100;
          4'ha: r = 16'd4000;
          4'hb: r = 16'd6000;
          4'hf: r = 16'd7500;
          default: r = 16'h0000;
        endcase
      end
      WSR_PM_PREC: begin
        case (code)
          4'h0, 4'h4: r = 16'd70;
          4'h1: r = 16'd2;
          4'h2: r = 16'd4;
          4'h3: r = 16'd9;
          4'h5: r = 16'd140;
          4'h6: r = 16'd280;
          4'h7: r = 16'd550;
          4'h8: r = 16'd800;
          4'hf: r = 16'd1000;
          default: r = 16'h0000;
        endcase
      end
      default: r = 16'h0000;
    endcase
    return r;
  endfunction : wsr_watch_dhz

  // Standby clock rate in tenths of a hertz
  function automatic logic [WSR_RATE_W-1:0] wsr_standby_dhz(input logic [2:0] pm, input logic [2:0] code);
    logic [WSR_RATE_W-1:0] r;
    r = 16'h0000;
    case (pm)
      WSR_PM_ULP: begin
        case (code)
          3'h0: r = 16'd10;
          3'h1: r = 16'd30;
          3'h2: r = 16'd50;
          3'h3: r = 16'd100;
          3'h4: r = 16'd230;
          3'h5: r = 16'd450;
          3'h6: r = 16'd900;
          default: r = 16'd1800;
        endcase
      end
      WSR_PM_LP: begin
        case (code)
          3'h0: r = 16'd5;
          3'h1: r = 16'd10;
          3'h2: r = 16'd30;
          3'h3: r = 16'd60;
          3'h4: r = 16'd120;
          3'h5: r = 16'd240;
          3'h6: r = 16'd480;
          default: r = 16'd1000;
        endcase
      end
      WSR_PM_PREC: begin
        case (code)
          3'h0: r = 16'd1;
          3'h1: r = 16'd2;
          3'h2: r = 16'd4;
          3'h3: r = 16'd8;
          3'h4: r = 16'd15;
          3'h5: r = 16'd30;
          3'h6: r = 16'd50;
          default: r = 16'd100;
        endcase
      end
      default: r = 16'h0000;
    endcase
    return r;
  endfunction : wsr_standby_dhz

endpackage : wsr_pkg

//--- design/wsr_rate_select.sv
`timescale 1ns/1ps

// Phase-accumulating divider; one-cycle tick at rate_dhz tenths of a hertz
module wsr_tick_gen #(
  parameter int CLK_HZ = wsr_pkg::WSR_CLK_HZ
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [wsr_pkg::WSR_RATE_W-1:0] rate_dhz,
  output logic tick_q
);
  localparam logic [35:0] LIMIT = 36'(CLK_HZ) * 36'd10;
  logic [35:0] acc_q;
  logic [35:0] sum;

  assign sum = acc_q + 36'(rate_dhz);

  // Accumulator avoids a divider per rate; zero rate parks it
  always_ff @(posedge core_clk) begin
    if (srst || rate_dhz == '0) begin
      acc_q <= '0;
      tick_q <= 1'b0;
    end else if (sum >= LIMIT) begin
      acc_q <= sum - LIMIT;
      tick_q <= 1'b1;
    end else begin
      acc_q <= sum;
      tick_q <= 1'b0;
    end
  end
endmodule : wsr_tick_gen

// What this block does
// RULE1: Rate-control register at index 0x12, read-write, cleared to zero by reset.
// RULE2: Bits 3:0 pick the activity-watch sampling rate; codes 1101, 1110 unsupported.
// RULE3: Bits 7:5 pick the standby clock rate from 0.1 Hz up to 180 Hz.
// RULE4: Power mode 3, 0 or 4 selects ultra-low, low or precision frequencies.
// RULE5: Watch and standby frequency tables differ from the wake-rate tables.
// RULE6: Software always writes zero to bit 4.
// RULE7: Software avoids watch codes unavailable in the current power mode.
module wsr_rate_select
  import wsr_pkg::*;
#(
  parameter int CLK_HZ = WSR_CLK_HZ
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [2:0] power_mode,
  input wire logic [WSR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [WSR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] watch_rate_code,
  output logic [2:0] standby_clock_code,
  output logic watch_tick,
  output logic standby_tick,
  output logic watch_code_supported
);

  wsr_rate_ctrl_t ctrl_q;
  wsr_status_t status_q;
  logic aw_have_q;
  logic w_have_q;
  logic [WSR_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_go;
  logic [WSR_RATE_W-1:0] watch_dhz;
  logic [WSR_RATE_W-1:0] standby_dhz;
  logic watch_tick_i;
  logic standby_tick_i;

  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  // Write address capture; ready drops while an address is held
  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // Write data capture, independent of the address channel
  always_ff @(posedge core_clk) begin
    if (srst) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_have_q <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // Write response once both halves are in
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= WSR_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_q[WSR_ADDR_W-1:2] == WSR_RATE_CTRL_ADDR[WSR_ADDR_W-1:2]) ? WSR_RESP_OKAY
                                                                                       : WSR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Rate-control register; bit 4 is stored as zero whatever arrives
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= wsr_rate_ctrl_t'(WSR_RATE_CTRL_RST); // [RULE1]
    end else if (wr_go && w_strb_q[0] &&
                 aw_addr_q[WSR_ADDR_W-1:2] == WSR_RATE_CTRL_ADDR[WSR_ADDR_W-1:2]) begin
      ctrl_q.watch_rate_code <= w_data_q[WSR_WATCH_LSB +: 4]; // [RULE1] [RULE2]
      ctrl_q.standby_clock_code <= w_data_q[WSR_STANDBY_LSB +: 3]; // [RULE1] [RULE3]
      ctrl_q.zero_bit <= 1'b0; // [RULE6]
    end
  end

  // Read channel: one read in flight, answer one cycle after the address
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= WSR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr[WSR_ADDR_W-1:2] == WSR_RATE_CTRL_ADDR[WSR_ADDR_W-1:2]) begin
        s_axi_rdata <= {24'h000000, ctrl_q}; // [RULE1]
        s_axi_rresp <= WSR_RESP_OKAY;
      end else if (s_axi_araddr[WSR_ADDR_W-1:2] == WSR_STATUS_ADDR[WSR_ADDR_W-1:2]) begin
        s_axi_rdata <= {30'h0, status_q};
        s_axi_rresp <= WSR_RESP_OKAY;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= WSR_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Frequency lookup per power mode; tables are specific to watch/standby
  assign watch_dhz = wsr_watch_dhz(power_mode, ctrl_q.watch_rate_code); // [RULE2] [RULE4] [RULE5]
  assign standby_dhz = wsr_standby_dhz(power_mode, ctrl_q.standby_clock_code); // [RULE3] [RULE4] [RULE5]

  // Unsupported codes simply stop the tick rather than guessing a rate
  wsr_tick_gen #(.CLK_HZ(CLK_HZ)) u_watch_tick (
    .core_clk(core_clk),
    .srst(srst),
    .rate_dhz(watch_dhz),
    .tick_q(watch_tick_i)
  );

  wsr_tick_gen #(.CLK_HZ(CLK_HZ)) u_standby_tick (
    .core_clk(core_clk),
    .srst(srst),
    .rate_dhz(standby_dhz),
    .tick_q(standby_tick_i)
  );

  // Status flags, one cycle behind the settings they describe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_q <= '0;
    end else begin
      status_q.watch_code_supported <= (watch_dhz != '0); // [RULE7]
      status_q.power_mode_known <= (standby_dhz != '0); // [RULE4]
    end
  end

  // Registered user-side outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      watch_rate_code <= '0;
      standby_clock_code <= '0;
      watch_tick <= 1'b0;
      standby_tick <= 1'b0;
      watch_code_supported <= 1'b0;
    end else begin
      watch_rate_code <= ctrl_q.watch_rate_code;
      standby_clock_code <= ctrl_q.standby_clock_code;
      watch_tick <= watch_tick_i;
      standby_tick <= standby_tick_i;
      watch_code_supported <= status_q.watch_code_supported;
    end
  end

endmodule : wsr_rate_select

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import wsr_pkg::*;
  logic core_clk, srst, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, wt, st, sup;
  logic [2:0] pm, sbc;
  logic [3:0] wrc, stb;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0] bresp, rresp;
  int errors, n_checks, nw, ns;
  int cyc = 0;
  int we[3] = '{260, 150, 20};
  int se[3] = '{36, 20, 2};
  logic [2:0] pms[3] = '{WSR_PM_ULP, WSR_PM_LP, WSR_PM_PREC};

  // Small clock figure keeps tick periods between about 8 and 1000 cycles
  wsr_rate_select #(.CLK_HZ(10000)) i_wsr_rate_select (.core_clk(core_clk), .srst(srst), .power_mode(pm),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(stb),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .watch_rate_code(wrc), .standby_clock_code(sbc), .watch_tick(wt),
    .standby_tick(st), .watch_code_supported(sup));

  // Clock at 4 ns
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task check(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check

  task end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awa <= a; wd <= d; stb <= s; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awv && awr) begin ta = 1'b1; awv <= 1'b0; end
      if (wv && wrdy) begin tw = 1'b1; wv <= 1'b0; end
    end while (!(ta && tw && bv));
    br <= 1'b0;
    check({30'h0, bresp}, {30'h0, e});
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    check(rdat, d);
    check({30'h0, rresp}, {30'h0, e});
    @(posedge core_clk);
  endtask : rd

  // Settle, then count both ticks over a 2000-cycle window
  task automatic ticks(output int a, output int b);
    a = 0;
    b = 0;
    repeat (8) @(posedge core_clk);
    repeat (2000) begin
      @(posedge core_clk);
      a += int'(wt);
      b += int'(st);
    end
  endtask : ticks

  // Hang guard; the full run needs about 12000 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc > 40000) begin errors++; end_sim(); end
  end

  initial begin
    srst = 1'b1; pm = WSR_PM_ULP; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
    awa = 8'h00; ara = 8'h00; wd = 32'h0; stb = 4'h0; errors = 0; n_checks = 0;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    rd(WSR_RATE_CTRL_ADDR, 32'h0, WSR_RESP_OKAY);
    wr(WSR_RATE_CTRL_ADDR, 32'hef, 4'h1, WSR_RESP_OKAY);
    rd(WSR_RATE_CTRL_ADDR, 32'hef, WSR_RESP_OKAY);
    check({28'h0, wrc}, 32'hf);
    check({29'h0, sbc}, 32'h7);
    wr(WSR_RATE_CTRL_ADDR, 32'h0, 4'h0, WSR_RESP_OKAY);
    rd(WSR_RATE_CTRL_ADDR, 32'hef, WSR_RESP_OKAY);
    wr(8'h80, 32'h1, 4'h1, WSR_RESP_SLVERR);
    rd(8'h80, 32'h0, WSR_RESP_SLVERR);
    $display("register test done");
    // Fastest codes in each power mode, then an unsupported code
    for (int i = 0; i < 3; i++) begin
      pm <= pms[i];
      wr(WSR_RATE_CTRL_ADDR, 32'hef, 4'h1, WSR_RESP_OKAY);
      ticks(nw, ns);
      check(32'((nw > we[i] - 3) && (nw < we[i] + 3)), 32'h1);
      check(32'((ns > se[i] - 3) && (ns < se[i] + 3)), 32'h1);
      rd(WSR_STATUS_ADDR, 32'h3, WSR_RESP_OKAY);
      wr(WSR_RATE_CTRL_ADDR, 32'h0d, 4'h1, WSR_RESP_OKAY);
      ticks(nw, ns);
      check(32'(nw), 32'h0);
      rd(WSR_STATUS_ADDR, 32'h2, WSR_RESP_OKAY);
    end
    $display("rate test done");
    wr(WSR_RATE_CTRL_ADDR, 32'h09, 4'h1, WSR_RESP_OKAY);
    repeat (4) @(posedge core_clk);
    check({31'h0, sup}, 32'h0);
    // Same code is available in low power, so the flag must return
    pm <= WSR_PM_LP;
    repeat (4) @(posedge core_clk);
    check({31'h0, sup}, 32'h1);
    // Undefined power-mode value gives no rate at all
    pm <= 3'h1;
    repeat (4) @(posedge core_clk);
    check({31'h0, sup}, 32'h0);
    rd(WSR_STATUS_ADDR, 32'h0, WSR_RESP_OKAY);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rd(WSR_RATE_CTRL_ADDR, 32'h0, WSR_RESP_OKAY);
    $display("reset test done");
    end_sim();
  end
endmodule : tb_top

//--- tb/wsr_rate_select_properties.sv
`timescale 1ns/1ps
module wsr_rate_select_checker
  import wsr_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [2:0] power_mode,
  input wire logic [WSR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] watch_rate_code,
  input wire logic [2:0] standby_clock_code,
  input wire logic watch_tick,
  input wire logic watch_code_supported
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [7:0] wdat_q;
  // Last written byte, so field outputs can be compared later
  always_ff @(posedge core_clk) begin
    if (s_axi_wvalid && s_axi_wready) begin
      wdat_q <= s_axi_wdata[7:0];
    end
  end
  // Both write channels taken with no response pending
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence rate_wr;
    wr_take ##0 (s_axi_awaddr[7:2] == WSR_RATE_CTRL_IDX[5:0] && s_axi_wstrb[0]);
  endsequence
  chk_write_answer: assert property (wr_take |-> ##[1:3] s_axi_bvalid) else $error("no bresp");
  chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid drop");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid) else $error("no rdata");
  chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata)) else $error("rdata moved");
  chk_fields_follow: assert property (rate_wr |-> ##[2:4] {standby_clock_code, watch_rate_code} ==
    {wdat_q[7:5], wdat_q[3:0]}) else $error("codes differ from write");
  chk_bit_four_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[4]) else $error("bit 4 set");
  chk_unsup_code: assert property ((watch_rate_code inside {4'hd, 4'he})[*2] |-> !watch_code_supported)
    else $error("bad code supported");
  chk_no_tick: assert property ((!watch_code_supported)[*4] |-> !watch_tick) else $error("tick unsupported");
  chk_prec_limit: assert property ((power_mode == WSR_PM_PREC && watch_rate_code inside {[4'h9:4'hc]})[*3]
    |-> !watch_code_supported) else $error("precision code supported");
endmodule : wsr_rate_select_checker

bind wsr_rate_select wsr_rate_select_checker i_chk (.core_clk(core_clk), .srst(srst), .power_mode(power_mode),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .watch_rate_code(watch_rate_code), .standby_clock_code(standby_clock_code),
  .watch_tick(watch_tick), .watch_code_supported(watch_code_supported));
